// file: spc_serial_port.v
// byte-wide serial peripheral port, master or slave, with apb register access
// assumes pins are resolved outside from out/oe pairs; ss_is_input and irq_ack come from pclk logic
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "spc_defines.vh"

module spc_serial_port (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial pins
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        mosi_in,
  output wire        mosi_out,
  output reg         mosi_oe,
  input  wire        miso_in,
  output wire        miso_out,
  output reg         miso_oe,
  input  wire        ss_n_in,
  input  wire        ss_is_input,
  // interrupt
  input  wire        irq_ack,
  output reg         irq,
  output reg  [1:0]  irq_level
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [7:0] shin;
    input [7:0] v;
    input       b;
    input       lsbf;
    begin
      shin = lsbf ? {b, v[7:1]} : {v[6:0], b};
    end
  endfunction

  function [6:0] reload;
    input [1:0] ps;
    input       x2;
    begin
      case (ps)
        2'h0:    reload = x2 ? `SPC_RLD_DIV2  : `SPC_RLD_DIV4;
        2'h1:    reload = x2 ? `SPC_RLD_DIV8  : `SPC_RLD_DIV16;
        2'h2:    reload = x2 ? `SPC_RLD_DIV32 : `SPC_RLD_DIV64;
        default: reload = x2 ? `SPC_RLD_DIV64 : `SPC_RLD_DIV128;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0] ctrl;
  reg  [7:0] spi_interrupt_control;
  reg  [1:0] bufmode;
  reg        slave_select_disable;
  reg  [7:0] sr;
  reg  [7:0] tx_buf;
  reg        tx_full;
  reg  [7:0] rx_mem [0:1];
  reg  [1:0] rx_cnt;
  reg        busy;
  reg  [3:0] edge_cnt;
  reg  [6:0] div_cnt;
  reg        in_bit;
  reg        ser_out;
  reg        xfer_flag;
  reg        wcol_flag;
  reg        tx_done_flag;
  reg        sel_lost_flag;
  reg        pend_xfer;
  reg        pend_wcol;
  reg        sck_s1, sck_s2, sck_s3;
  reg        mosi_s1, mosi_s2;
  reg        ssn_s1, ssn_s2;
  reg  [7:0] next_sr;
  reg        next_busy;
  reg  [3:0] next_edge;
  reg  [6:0] next_div;
  reg        next_sck;
  reg        next_in;
  reg  [7:0] rd_byte;

  // ----------------------------------------------------------------
  // decoded controls and events
  // ----------------------------------------------------------------
  wire       en       = ctrl[`SPC_CTRL_EN];
  wire       mst      = ctrl[`SPC_CTRL_MST];
  wire       lsbf     = ctrl[`SPC_CTRL_LSBF];
  wire       cpol     = ctrl[`SPC_CTRL_CPOL];
  wire       cpha     = ctrl[`SPC_CTRL_CPHA];
  wire       buffered = bufmode[1];
  wire [5:0] idx      = paddr[7:2];
  wire       acc      = psel & penable & pready;
  wire       wr       = acc & pwrite;
  wire       rd       = acc & ~pwrite;
  wire       data_acc = acc & (idx == `SPC_IDX_DATA);
  wire       data_wr  = wr & (idx == `SPC_IDX_DATA);
  wire       st_wr    = wr & (idx == `SPC_IDX_STATUS) & buffered;
  wire       st_rd    = rd & (idx == `SPC_IDX_STATUS);
  // a fault needs ss as input, held low, while master and not disabled
  wire       fault    = en & mst & ss_is_input & ~ssn_s2 & ~slave_select_disable;
  wire       run      = en & ~fault;
  // master reads miso unsynchronised: it moves on our own sck, too late for two flops at fast dividers
  wire       din      = mst ? miso_in : mosi_s2;
  wire       m_tick   = run & mst & busy & (div_cnt == 7'h00);
  wire       s_edge   = run & ~mst & ~ssn_s2 & (sck_s2 != sck_s3);
  wire       edge_ev  = m_tick | s_edge;
  wire       smp_edge = edge_ev & (edge_cnt[0] == cpha);
  wire       sft_edge = edge_ev & (edge_cnt[0] != cpha) & (edge_cnt != 4'h0);
  wire       done     = edge_ev & (edge_cnt == `SPC_LAST_EDGE);
  wire [7:0] rx_byte  = shin(sr, cpha ? din : in_bit, lsbf);
  wire       active   = busy | (edge_cnt != 4'h0);
  wire       done_ld  = done & buffered & tx_full;
  // mode 2 moves a waiting byte into an idle shifter at once
  wire       load_now = run & (bufmode == `SPC_BUF_MODE2) & tx_full & ~active;
  // mode 1 sends the shifter content as a dummy first byte
  wire       dummy_go = run & mst & ~busy & (bufmode == `SPC_BUF_MODE1) & tx_full;
  wire       ub_load  = run & data_wr & ~buffered & ~active;
  wire       rx_pop   = rd & (idx == `SPC_IDX_DATA) & buffered & (rx_cnt != 2'h0);
  wire       rx_flush = st_wr & pwdata[`SPC_ST_RXD];
  wire       rx_done  = rx_cnt != 2'h0;
  wire       tx_empty = ~tx_full;
  wire [3:0] srcs     = {rx_done, tx_done_flag, tx_empty, sel_lost_flag};
  wire       req      = buffered ? |(spi_interrupt_control[7:4] & srcs) : xfer_flag;

  assign mosi_out = ser_out;
  assign miso_out = ser_out;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      ssn_s1  <= 1'b1;
      ssn_s2  <= 1'b1;
    end else begin
      sck_s1  <= sck_in;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      ssn_s1  <= ss_n_in;
      ssn_s2  <= ssn_s1;
    end
  end

  // ----------------------------------------------------------------
  // shift engine, next state
  // ----------------------------------------------------------------
  always @* begin
    next_sr   = sr;
    next_busy = busy;
    next_edge = edge_cnt;
    next_div  = div_cnt;
    next_sck  = sck_out;
    next_in   = in_bit;
    if (!run) begin
      next_busy = 1'b0;
      next_edge = 4'h0;
      next_sck  = cpol;
    end else begin
      if (edge_ev) begin
        next_edge = edge_cnt + 4'h1;
        if (smp_edge)
          next_in = din;
        if (sft_edge)
          next_sr = shin(sr, in_bit, lsbf);
        if (done)
          next_sr = rx_byte;
      end
      if (mst) begin
        if (!busy) begin
          next_sck  = cpol;
          next_edge = 4'h0;
        end else if (div_cnt == 7'h00) begin
          next_div = reload(ctrl[1:0], ctrl[`SPC_CTRL_X2]);
          next_sck = ~sck_out;
        end else begin
          next_div = div_cnt - 7'h01;
        end
      end else begin
        next_sck = cpol;
        // raising select drops a partial byte
        if (ssn_s2)
          next_edge = 4'h0;
      end
      if (done) begin
        if (done_ld)
          next_sr = tx_buf;
        else if (mst)
          next_busy = 1'b0;
      end
      if (load_now)
        next_sr = tx_buf;
      if (ub_load)
        next_sr = pwdata[7:0];
      if (mst && ((load_now || ub_load || dummy_go) && !busy)) begin
        next_busy = 1'b1;
        next_div  = reload(ctrl[1:0], ctrl[`SPC_CTRL_X2]);
        next_edge = 4'h0;
        next_sck  = cpol;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr       <= `SPC_RESET_BYTE;
      busy     <= 1'b0;
      edge_cnt <= 4'h0;
      div_cnt  <= 7'h00;
      sck_out  <= 1'b0;
      in_bit   <= 1'b0;
      ser_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      sr       <= next_sr;
      busy     <= next_busy;
      edge_cnt <= next_edge;
      div_cnt  <= next_div;
      sck_out  <= next_sck;
      in_bit   <= next_in;
      ser_out  <= lsbf ? next_sr[0] : next_sr[7];
      sck_oe   <= en & mst & ~fault;
      mosi_oe  <= en & mst & ~fault;
      miso_oe  <= en & ~mst & ~ssn_s2;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer: one deep unbuffered, two deep buffered
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mem[0] <= `SPC_RESET_BYTE;
      rx_mem[1] <= `SPC_RESET_BYTE;
      rx_cnt    <= 2'h0;
    end else if (rx_flush || !buffered) begin
      if (done) begin
        rx_mem[0] <= rx_byte;
        rx_cnt    <= 2'h1;
      end else if (rx_flush) begin
        rx_cnt <= 2'h0;
      end
    end else begin
      case ({done, rx_pop})
        2'b10: begin
          // a third byte is dropped while two wait
          if (rx_cnt < `SPC_RX_DEPTH) begin
            rx_mem[rx_cnt[0]] <= rx_byte;
            rx_cnt            <= rx_cnt + 2'h1;
          end
        end
        2'b01: begin
          rx_mem[0] <= rx_mem[1];
          rx_cnt    <= rx_cnt - 2'h1;
        end
        2'b11: begin
          if (rx_cnt == 2'h1) begin
            rx_mem[0] <= rx_byte;
          end else begin
            rx_mem[0] <= rx_mem[1];
            rx_mem[1] <= rx_byte;
          end
        end
        default: begin
          rx_cnt <= rx_cnt;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `SPC_RESET_BYTE;
      spi_interrupt_control <= `SPC_RESET_BYTE;
      bufmode <= `SPC_BUF_OFF;
      slave_select_disable     <= 1'b0;
    end else begin
      if (wr && idx == `SPC_IDX_CTRL)
        ctrl <= pwdata[7:0];
      else if (fault)
        ctrl[`SPC_CTRL_MST] <= 1'b0;
      if (wr && idx == `SPC_IDX_SPI_INTERRUPT_CONTROL) begin
        if (buffered)
          spi_interrupt_control <= pwdata[7:0] & `SPC_INTEN_MASK;
        else
          spi_interrupt_control <= {spi_interrupt_control[7:2], pwdata[1:0]};
      end
      if (wr && idx == `SPC_IDX_CTRLB) begin
        bufmode <= pwdata[7:6];
        slave_select_disable     <= pwdata[`SPC_CTRLB_SSD];
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags; a hardware set wins over any clear
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_flag     <= 1'b0;
      wcol_flag     <= 1'b0;
      pend_xfer     <= 1'b0;
      pend_wcol     <= 1'b0;
      tx_done_flag  <= 1'b0;
      sel_lost_flag <= 1'b0;
      tx_buf        <= `SPC_RESET_BYTE;
      tx_full       <= 1'b0;
    end else begin
      xfer_flag <= (~buffered & (done | fault))
                   | (xfer_flag & ~irq_ack & ~(data_acc & pend_xfer));
      wcol_flag <= (~buffered & data_wr & active) | (wcol_flag & ~(data_acc & pend_wcol));
      if (data_acc) begin
        pend_xfer <= 1'b0;
        pend_wcol <= 1'b0;
      end else if (st_rd && !buffered) begin
        pend_xfer <= prdata[`SPC_ST_XFER];
        pend_wcol <= prdata[`SPC_ST_WCOL];
      end
      tx_done_flag  <= (done & buffered & ~tx_full)
                       | (tx_done_flag & ~(st_wr & pwdata[`SPC_ST_TXD]));
      sel_lost_flag <= (fault & buffered) | (sel_lost_flag & ~(st_wr & pwdata[`SPC_ST_SEL]));
      if (data_wr && buffered) begin
        tx_buf  <= pwdata[7:0];
        tx_full <= 1'b1;
      end else if (done_ld || load_now) begin
        tx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read mux and answer; one wait state on every access
  // ----------------------------------------------------------------
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `SPC_IDX_CTRL:    rd_byte = ctrl;
      `SPC_IDX_SPI_INTERRUPT_CONTROL: rd_byte = buffered ? spi_interrupt_control : {6'h00, spi_interrupt_control[1:0]};
      `SPC_IDX_STATUS:  rd_byte = buffered ? {srcs, 4'h0} : {xfer_flag, wcol_flag, 6'h00};
      `SPC_IDX_DATA:    rd_byte = rx_mem[0];
      `SPC_IDX_CTRLB:   rd_byte = {bufmode, 3'h0, slave_select_disable, 2'h0};
      default:          rd_byte = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
      irq_level <= 2'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (idx > `SPC_IDX_LAST);
      if (psel && penable && !pready)
        prdata <= {24'h000000, rd_byte};
      irq       <= req & (|spi_interrupt_control[1:0]);
      irq_level <= req ? spi_interrupt_control[1:0] : 2'h0;
    end
  end

endmodule

// file: spc_defines.vh
// register indices, field positions, codes and divider reloads of the serial port
// assumes inclusion by bare name from the serial port design file
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPC_IDX_CTRL    6'h00
`define SPC_IDX_SPI_INTERRUPT_CONTROL 6'h01
`define SPC_IDX_STATUS  6'h02
`define SPC_IDX_DATA    6'h03
`define SPC_IDX_CTRLB   6'h04
`define SPC_IDX_LAST    6'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPC_CTRL_X2     7
`define SPC_CTRL_EN     6
`define SPC_CTRL_LSBF   5
`define SPC_CTRL_MST    4
`define SPC_CTRL_CPOL   3
`define SPC_CTRL_CPHA   2
`define SPC_ST_RXD      7
`define SPC_ST_TXD      6
`define SPC_ST_XFER     7
`define SPC_ST_WCOL     6
`define SPC_ST_SEL      4
`define SPC_CTRLB_SSD   2
`define SPC_INTEN_MASK  8'hF3
`define SPC_RESET_BYTE  8'h00

// ----------------------------------------------------------------
// buffer modes
// ----------------------------------------------------------------
`define SPC_BUF_OFF     2'h0
`define SPC_BUF_MODE1   2'h2
`define SPC_BUF_MODE2   2'h3

// ----------------------------------------------------------------
// half-period reload values (cycles per serial clock half, minus one)
// ----------------------------------------------------------------
`define SPC_RLD_DIV2    7'h00
`define SPC_RLD_DIV4    7'h01
`define SPC_RLD_DIV8    7'h03
`define SPC_RLD_DIV16   7'h07
`define SPC_RLD_DIV32   7'h0F
`define SPC_RLD_DIV64   7'h1F
`define SPC_RLD_DIV128  7'h3F
`define SPC_LAST_EDGE   4'hF
`define SPC_RX_DEPTH    2'h2

`endif

// file: spc_checker.sv
// concurrent checks on the serial port's apb, pin enable and interrupt outputs
// assumes binding onto spc_serial_port; sees only its ports
`timescale 1ns/100ps
module spc_checker (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // pins and interrupt
  input wire        sck_oe,
  input wire        mosi_oe,
  input wire        miso_oe,
  input wire        ss_n_in,
  input wire        ss_is_input,
  input wire        irq,
  input wire [1:0]  irq_level
);
  // ----------------------------------------------------------------
  // mirrors of written control bits, snooped off the bus
  // ----------------------------------------------------------------
  reg en_seen;
  reg ssd_seen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen <= 1'b0;
      ssd_seen <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr[7:2] == 6'h00) en_seen <= pwdata[6];
      if (paddr[7:2] == 6'h04) ssd_seen <= pwdata[2];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  a_ready_cause: assert property (pready |-> psel && penable) else $error("pready without access");
  a_slverr_map: assert property (pready |-> (pslverr == (paddr[7:2] > 6'h04))) else $error("pslverr wrong");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_irq_tie: assert property (irq == (irq_level != 2'h0)) else $error("irq and level disagree");
  a_oe_pair: assert property (mosi_oe == sck_oe) else $error("master enables split");
  a_role_excl: assert property (!(sck_oe && miso_oe)) else $error("master and slave at once");
  a_enable_gate: assert property (sck_oe |-> en_seen || $past(en_seen)) else $error("driving while off");
  a_fault_drop: assert property (sck_oe && ss_is_input && !ss_n_in && !ssd_seen |-> ##[1:5] !sck_oe)
    else $error("master kept after select fault");
  c_slverr: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_drop: cover property ($fell(sck_oe));
endmodule

// file: spc_partner.sv
// spi slave on the far side of the master port, mode 0, msb first
// assumes the bench lowers ss_n with tx_byte set before the first clock edge
`timescale 1ns/100ps
module spc_partner (
  // serial pins
  input  wire       sck,
  input  wire       mosi,
  input  wire       ss_n,
  output reg        miso,
  // byte side
  input  wire [7:0] tx_byte,
  output reg  [7:0] rx_byte
);
  reg [7:0] shift;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end
  always @(negedge ss_n) begin
    shift = tx_byte;
    miso = shift[7];
  end
  always @(posedge sck) begin
    if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  end
  always @(negedge sck) begin
    if (!ss_n) begin
      shift = {shift[6:0], 1'b0};
      miso = shift[7];
    end
  end
  // released line flips so a stale level cannot pass as data
  always @(posedge ss_n) miso = ~miso;
endmodule

// file: test_spi_control_status_regs.sv
// self-checking bench: apb master tasks, spi slave partner, one task per scenario
// assumes the designer's timing: one wait state per access, registered pins
`timescale 1ns/100ps
`include "spc_defines.vh"
module test_spi_control_status_regs;
  reg         pclk, presetn, psel, penable, pwrite, ss_n_in, ss_is_input, irq_ack, slv_ss_n, sck_q, err;
  reg  [7:0]  paddr, slv_tx, rd;
  reg  [31:0] pwdata;
  reg  [7:0]  divs [0:7];
  wire [31:0] prdata;
  wire        pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, slv_miso;
  wire [1:0]  irq_level;
  wire [7:0]  slv_rx;
  wire        sck_pin = sck_oe ? sck_out : 1'b0;
  wire        mosi_pin = mosi_oe ? mosi_out : ~mosi_out;
  wire        miso_pin = miso_oe ? miso_out : slv_miso;
  integer     miscompares, comparisons, n, i;
  spc_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_is_input(ss_is_input),
    .irq_ack(irq_ack), .irq(irq), .irq_level(irq_level));
  spc_partner slv_u (.sck(sck_pin), .mosi(mosi_pin), .ss_n(slv_ss_n), .miso(slv_miso), .tx_byte(slv_tx),
    .rx_byte(slv_rx));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) sck_q <= sck_out;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [5:0] idx, input [7:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no limit here: only the watchdog ends a wait
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input [5:0] idx, input [7:0] exp);
    begin
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
    end
  endtask
  // bounded wait for the next rising serial clock
  task rise;
    begin
      n = 0;
      @(posedge pclk);
      while (!(sck_out === 1'b1 && sck_q === 1'b0) && n < 300) begin
        n = n + 1;
        @(posedge pclk);
      end
    end
  endtask
  task xfer(input [7:0] ctl, tx, miso_b, exp_slv, exp_rd, input col, input [7:0] st);
    begin
      apb(1'b1, `SPC_IDX_CTRL, ctl);
      slv_tx <= miso_b;
      slv_ss_n <= 1'b0;
      apb(1'b1, `SPC_IDX_DATA, tx);
      rise;
      rise;
      chk(n[7:0] + 8'h01, divs[{ctl[7], ctl[1:0]}]);
      if (col) apb(1'b1, `SPC_IDX_DATA, 8'hFF);
      n = 0;
      apb(1'b0, `SPC_IDX_STATUS, 8'h00);
      while (rd[7] !== 1'b1 && n < 400) begin
        n = n + 1;
        apb(1'b0, `SPC_IDX_STATUS, 8'h00);
      end
      chk(rd, st);
      chk({5'h0, irq, irq_level}, 8'h06);
      slv_ss_n <= 1'b1;
      chk(slv_rx, exp_slv);
      rdchk(`SPC_IDX_DATA, exp_rd);
      // buffered: transmit done and empty stay set after the data read
      rdchk(`SPC_IDX_STATUS, st & {1'b0, {2{st[5]}}, 5'h00});
      chk({7'h0, irq}, 8'h00);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      rdchk(`SPC_IDX_CTRL, 8'h00);
      rdchk(`SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h00);
      rdchk(`SPC_IDX_STATUS, 8'h00);
      apb(1'b0, 6'h05, 8'h00);
      chk({7'h0, err}, 8'h01);
      chk(rd, 8'h00);
    end
  endtask
  task t_buffered;
    begin
      apb(1'b1, `SPC_IDX_CTRLB, 8'h80);
      rdchk(`SPC_IDX_STATUS, 8'h20);
      apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'hFF);
      rdchk(`SPC_IDX_SPI_INTERRUPT_CONTROL, 8'hF3);
      apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h21);
      repeat (2) @(posedge pclk);
      chk({5'h0, irq, irq_level}, 8'h05);
      apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h11);
      repeat (2) @(posedge pclk);
      chk({7'h0, irq}, 8'h00);
      apb(1'b1, `SPC_IDX_CTRLB, 8'h00);
      apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'hFF);
      rdchk(`SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h03);
    end
  endtask
  task t_idle_modes;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apb(1'b1, `SPC_IDX_CTRL, {4'h5, i[1:0], 2'b00});
        repeat (2) @(posedge pclk);
        chk({7'h0, sck_out}, {7'h0, i[1]});
      end
    end
  endtask
  task t_disabled;
    begin
      apb(1'b1, `SPC_IDX_CTRL, 8'h10);
      apb(1'b1, `SPC_IDX_DATA, 8'h55);
      repeat (40) @(posedge pclk);
      chk({7'h0, sck_oe}, 8'h00);
      rdchk(`SPC_IDX_STATUS, 8'h00);
    end
  endtask
  task t_fault;
    begin
      apb(1'b1, `SPC_IDX_CTRL, 8'h50);
      ss_is_input <= 1'b1;
      ss_n_in <= 1'b0;
      repeat (6) @(posedge pclk);
      ss_n_in <= 1'b1;
      rdchk(`SPC_IDX_CTRL, 8'h40);
      rdchk(`SPC_IDX_STATUS, 8'h80);
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      rdchk(`SPC_IDX_STATUS, 8'h00);
      ss_is_input <= 1'b0;
    end
  endtask
  task t_buf_xfer;
    begin
      apb(1'b1, `SPC_IDX_CTRLB, 8'hC0);
      apb(1'b1, `SPC_IDX_STATUS, 8'h80);
      rdchk(`SPC_IDX_STATUS, 8'h20);
      apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h82);
      xfer(8'h51, 8'h96, 8'h69, 8'h96, 8'h69, 1'b0, 8'hE0);
      apb(1'b1, `SPC_IDX_STATUS, 8'h40);
      rdchk(`SPC_IDX_STATUS, 8'h20);
      apb(1'b1, `SPC_IDX_CTRLB, 8'h00);
    end
  endtask
  task tally_and_finish;
    begin
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, ss_is_input, irq_ack, err} = 7'h00;
    {ss_n_in, slv_ss_n} = 2'b11;
    {paddr, slv_tx, rd, pwdata} = 56'h0;
    {divs[0], divs[1], divs[2], divs[3]} = {8'd4, 8'd16, 8'd64, 8'd128};
    {divs[4], divs[5], divs[6], divs[7]} = {8'd2, 8'd8, 8'd32, 8'd64};
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_buffered;
    t_idle_modes;
    t_disabled;
    apb(1'b1, `SPC_IDX_SPI_INTERRUPT_CONTROL, 8'h02);
    for (i = 0; i < 8; i = i + 1) begin
      xfer({i[2], 3'b101, 2'b00, i[1:0]}, 8'hA5 ^ i[7:0], 8'h3C ^ i[7:0], 8'hA5 ^ i[7:0], 8'h3C ^ i[7:0], 1'b0,
        8'h80);
    end
    xfer(8'h70, 8'h01, 8'h01, 8'h80, 8'h80, 1'b1, 8'hC0);
    t_buf_xfer;
    t_fault;
    tally_and_finish;
  end
endmodule
bind spc_serial_port spc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_is_input(ss_is_input),
  .irq(irq), .irq_level(irq_level));
